// ### hw/usbsc_cfg.svh
// Purpose: Constants for the USB SIE control block and its firmware-side controller
// Assumes: 100 MHz clock; control byte reached over the block's own interface
// Notes: Definitions only
`ifndef USBSC_CFG_SVH
`define USBSC_CFG_SVH

// ----------------------------------------
// Control byte field positions
// ----------------------------------------
`define USBSC_BIT_PPRST 6
`define USBSC_BIT_SE0 5
`define USBSC_BIT_PKT_DISABLE 4
`define USBSC_BIT_EN 3
`define USBSC_BIT_RESUME 2
`define USBSC_BIT_SUSPEND 1
`define USBSC_CTL_RESET 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define USBSC_CLK_MHZ 100
`define USBSC_PLL_LOCK_MS 2
`define USBSC_RESUME_MS 10
`define USBSC_PLL_LOCK_CYC (`USBSC_PLL_LOCK_MS * 1000 * `USBSC_CLK_MHZ)
`define USBSC_RESUME_CYC (`USBSC_RESUME_MS * 1000 * `USBSC_CLK_MHZ)
`define USBSC_TMR_W 20

// ----------------------------------------
// Controller register map (byte offsets)
// ----------------------------------------
`define USBSC_OFS_CTRL 8'h00
`define USBSC_OFS_STAT 8'h04
`define USBSC_OFS_CMD 8'h08
`define USBSC_CMD_ATTACH 0
`define USBSC_CMD_WAKE 1
`define USBSC_CMD_AUTOSUSP 2
`define USBSC_HSIZE_WORD 3'h2

`endif

// ### hw/usbsc_pkg.sv
// Purpose: Types shared by the USB SIE control ends
// Assumes: Nothing imported by users
// Notes: One-hot controller states
package usbsc_pkg;

  typedef logic [7:0] usbsc_byte_t;

  typedef enum logic [2:0] {
    USBSC_ST_IDLE = 3'h1,
    USBSC_ST_PLL_WAIT = 3'h2,
    USBSC_ST_WAKE = 3'h4
  } usbsc_fsm_t;

endpackage : usbsc_pkg

// ### hw/usbsc_if.sv
// Purpose: Control byte port between firmware controller and SIE control
// Assumes: Both ends on clk
// Notes: A write is a one-cycle strobe with the whole byte
interface usbsc_if;
  logic ctl_wr;
  usbsc_pkg::usbsc_byte_t ctl_wdata;
  usbsc_pkg::usbsc_byte_t ctl_rdata;

  modport dev (
    input ctl_wr,
    input ctl_wdata,
    output ctl_rdata
  );

  modport fw (
    output ctl_wr,
    output ctl_wdata,
    input ctl_rdata
  );
endinterface : usbsc_if

// ### hw/usbsc_timer.sv
// Purpose: Down counter giving a sticky expiry level
// Assumes: start is a one-cycle pulse
// Notes: Expiry rises load cycles after start and holds until the next start
module usbsc_timer #(
  parameter int W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  input wire logic [W-1:0] load_val,
  output logic expired
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic exp_q;
  logic exp_d;

  always_comb begin
    cnt_d = cnt_q;
    exp_d = exp_q;
    if (start) begin
      cnt_d = load_val;
      exp_d = 1'b0;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
      exp_d = (cnt_q == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule : usbsc_timer

// ### hw/usbsc_fw_ctrl.sv
// Purpose: Firmware-side controller: AHB-Lite registers driving the SIE control byte
// Assumes: Zero-wait AHB-Lite slave, word transfers only
// Notes: Runs attach and remote-wake timing sequences itself
//
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`include "usbsc_cfg.svh"

module usbsc_fw_ctrl #(
  parameter int unsigned PLL_LOCK_CYC = `USBSC_PLL_LOCK_CYC,
  parameter int unsigned RESUME_CYC = `USBSC_RESUME_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Engine events
  input wire logic bus_idle_interrupt,
  input wire logic bus_activity_interrupt,
  // Clock source
  output logic pll_on,
  // Control byte port
  usbsc_if.fw ctl
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  usbsc_pkg::usbsc_fsm_t st_q, st_d;
  logic wpend_q, wpend_d;
  logic [7:0] addr_q, addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic pll_q, pll_d;
  logic auto_q, auto_d;
  logic att_q, att_d;
  logic wake_q, wake_d;
  logic idle_q, idle_d;
  logic act_q, act_d;
  logic wr_q, wr_d;
  usbsc_pkg::usbsc_byte_t wdat_q, wdat_d;
  logic tmr_start;
  logic [`USBSC_TMR_W-1:0] tmr_load;
  logic tmr_exp;
  logic host_ctl;
  logic host_cmd;
  usbsc_pkg::usbsc_byte_t base;

  usbsc_timer #(.W(`USBSC_TMR_W)) u_tmr (
    .clk(clk),
    .rst_n(rst_n),
    .start(tmr_start),
    .load_val(tmr_load),
    .expired(tmr_exp)
  );

  // ----------------------------------------
  // Bus and sequences
  // ----------------------------------------
  always_comb begin
    wpend_d = 1'b0;
    addr_d = addr_q;
    hrdata_d = hrdata_q;
    st_d = st_q;
    pll_d = pll_q;
    auto_d = auto_q;
    wr_d = 1'b0;
    wdat_d = wdat_q;
    tmr_start = 1'b0;
    tmr_load = `USBSC_TMR_W'(RESUME_CYC);
    host_ctl = wpend_q && (addr_q == `USBSC_OFS_CTRL);
    host_cmd = wpend_q && (addr_q == `USBSC_OFS_CMD);
    // Never write a zero that would clear the packet-disable flag by accident
    base = ctl.ctl_rdata | (8'h01 << `USBSC_BIT_PKT_DISABLE);
    att_d = att_q || (host_cmd && hwdata[`USBSC_CMD_ATTACH]);
    wake_d = wake_q || (host_cmd && hwdata[`USBSC_CMD_WAKE]);
    idle_d = idle_q || bus_idle_interrupt;
    act_d = act_q || bus_activity_interrupt;
    if (host_cmd) begin
      auto_d = hwdata[`USBSC_CMD_AUTOSUSP];
    end
    if (hsel && htrans[1] && hready) begin
      addr_d = haddr[7:0];
      wpend_d = hwrite && (hsize == `USBSC_HSIZE_WORD);
      case (haddr[7:0])
        `USBSC_OFS_CTRL: hrdata_d = {24'h00_0000, ctl.ctl_rdata};
        `USBSC_OFS_STAT: hrdata_d = {15'h0000, act_q, idle_q, wake_q, att_q, auto_q, pll_q, 3'(st_q),
                                     ctl.ctl_rdata};
        `USBSC_OFS_CMD: hrdata_d = {29'h0000_0000, auto_q, 2'b00};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    // Host writes to the control byte win over sequence steps, which then wait
    if (host_ctl) begin
      wr_d = 1'b1;
      wdat_d = hwdata[7:0];
    end
    case (st_q)
      usbsc_pkg::USBSC_ST_IDLE: begin
        if (att_q) begin
          att_d = host_cmd && hwdata[`USBSC_CMD_ATTACH];
          pll_d = 1'b1;
          tmr_start = 1'b1;
          tmr_load = `USBSC_TMR_W'(PLL_LOCK_CYC);
          st_d = usbsc_pkg::USBSC_ST_PLL_WAIT;
        end else if (wake_q && !host_ctl) begin
          wake_d = host_cmd && hwdata[`USBSC_CMD_WAKE];
          wr_d = 1'b1;
          wdat_d = (base & ~(8'h01 << `USBSC_BIT_SUSPEND)) | (8'h01 << `USBSC_BIT_RESUME);
          tmr_start = 1'b1;
          st_d = usbsc_pkg::USBSC_ST_WAKE;
        end else if (act_q && !host_ctl) begin
          act_d = bus_activity_interrupt;
          idle_d = bus_idle_interrupt;
          wr_d = 1'b1;
          wdat_d = base & ~(8'h01 << `USBSC_BIT_SUSPEND);
        end else if (idle_q && !host_ctl) begin
          idle_d = bus_idle_interrupt;
          // Suspend only after an idle indication, and only if allowed
          if (auto_q) begin
            wr_d = 1'b1;
            wdat_d = base | (8'h01 << `USBSC_BIT_SUSPEND);
          end
        end
      end
      usbsc_pkg::USBSC_ST_PLL_WAIT: begin
        if (tmr_exp && !host_ctl) begin
          wr_d = 1'b1;
          wdat_d = base | (8'h01 << `USBSC_BIT_EN);
          st_d = usbsc_pkg::USBSC_ST_IDLE;
        end
      end
      usbsc_pkg::USBSC_ST_WAKE: begin
        if (tmr_exp && !host_ctl) begin
          wr_d = 1'b1;
          wdat_d = base & ~(8'h01 << `USBSC_BIT_RESUME);
          st_d = usbsc_pkg::USBSC_ST_IDLE;
        end
      end
      default: st_d = usbsc_pkg::USBSC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= usbsc_pkg::USBSC_ST_IDLE;
      wpend_q <= 1'b0;
      addr_q <= 8'h00;
      hrdata_q <= 32'h0000_0000;
      pll_q <= 1'b0;
      auto_q <= 1'b0;
      att_q <= 1'b0;
      wake_q <= 1'b0;
      idle_q <= 1'b0;
      act_q <= 1'b0;
      wr_q <= 1'b0;
      wdat_q <= `USBSC_CTL_RESET;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      st_q <= st_d;
      wpend_q <= wpend_d;
      addr_q <= addr_d;
      hrdata_q <= hrdata_d;
      pll_q <= pll_d;
      auto_q <= auto_d;
      att_q <= att_d;
      wake_q <= wake_d;
      idle_q <= idle_d;
      act_q <= act_d;
      wr_q <= wr_d;
      wdat_q <= wdat_d;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = hrdata_q;
  assign pll_on = pll_q;
  assign ctl.ctl_wr = wr_q;
  assign ctl.ctl_wdata = wdat_q;

endmodule : usbsc_fw_ctrl

// ### hw/usbsc_sie_ctl.sv
// Purpose: SIE control byte: enable, ping-pong reset, packet disable, resume, suspend
// Assumes: Engine events on clk; clock-ok and SE0 arrive as pins
// Notes: Every output is registered
`include "usbsc_cfg.svh"

// Function
// - Enable bit 3 gates whole module
// - Enabling clears all ping-pong pointer bits
// - Enable turns on configured pull-ups
// - Other bits ignored while disabled
// - Enable refused without active clock source
// - Firmware powers PLL 2 ms before enable
// - Bit 5 reads live SE0 state
// - Firmware watches SE0 after enabling
// - Ping-pong reset bit 6 holds pointers even
// - Firmware clears ping-pong reset bit itself
// - Ping-pong reset ignored without ping-pong mode
// - SETUP token sets packet-disable bit 4, halting
// - Writes only clear packet-disable, resuming engine
// - Status FIFO events kept while disabled
// - Resume bit 2 drives resume signalling
// - Firmware holds resume 10 ms, then clears
// - Suspend bit 1 stops engine clock
// - Suspended: stay attached, transceiver idle
// - Firmware suspends on idle, wakes on activity
// - Never suspend before idle indication
// - Bits 7 and 0 read zero
module usbsc_sie_ctl #(
  parameter int NPP = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control byte port
  usbsc_if.dev ctl,
  // Pins
  input wire logic clk_src_active,
  input wire logic se0_line,
  // Configuration
  input wire logic pullup_cfg_en,
  input wire logic [1:0] pingpong_mode,
  // Engine events
  input wire logic setup_token_rx,
  input wire logic [NPP-1:0] pingpong_toggle,
  // Engine controls
  output logic module_enable,
  output logic pullup_on,
  output logic [NPP-1:0] pingpong_pointer_bit,
  output logic packet_proc_en,
  output logic status_fifo_retain,
  output logic resume_drive,
  output logic engine_clk_en,
  output logic low_power,
  output logic xcvr_tx_idle
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Both pins cross in from outside; only stage two is read
  logic [1:0] clk_ok_q, clk_ok_d;
  logic [1:0] se0_q, se0_d;

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  logic en_q, en_d;
  logic pprst_q, pprst_d;
  logic pkt_dis_q, pkt_dis_d;
  logic resume_q, resume_d;
  logic susp_q, susp_d;
  logic [NPP-1:0] ptr_q, ptr_d;
  usbsc_pkg::usbsc_byte_t rd_q, rd_d;
  logic pull_q, pull_d;
  logic pkt_q, pkt_d;
  logic keep_q, keep_d;
  logic res_q, res_d;
  logic eclk_q, eclk_d;
  logic lp_q, lp_d;
  logic idle_q, idle_d;
  logic pp_used;
  logic pp_hold;
  logic pp_clear;
  logic pkt_run;

  always_comb begin
    clk_ok_d = {clk_ok_q[0], clk_src_active};
    se0_d = {se0_q[0], se0_line};
    en_d = en_q;
    pprst_d = pprst_q;
    resume_d = resume_q;
    susp_d = susp_q;
    pkt_dis_d = pkt_dis_q;
    if (ctl.ctl_wr) begin
      // Setting the enable needs a live clock; clearing it always works
      en_d = ctl.ctl_wdata[`USBSC_BIT_EN] && (en_q || clk_ok_q[1]);
      pprst_d = ctl.ctl_wdata[`USBSC_BIT_PPRST];
      resume_d = ctl.ctl_wdata[`USBSC_BIT_RESUME];
      susp_d = ctl.ctl_wdata[`USBSC_BIT_SUSPEND];
      if (!ctl.ctl_wdata[`USBSC_BIT_PKT_DISABLE]) begin
        pkt_dis_d = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (en_q && !susp_q && setup_token_rx) begin
      pkt_dis_d = 1'b1;
    end
  end

  // ----------------------------------------
  // Ping-pong pointers
  // ----------------------------------------
  assign pp_used = (pingpong_mode != 2'b00);
  assign pp_hold = en_q && pprst_q && pp_used;
  assign pp_clear = en_d && !en_q;
  assign pkt_run = en_q && !pkt_dis_q && !susp_q;
  // Outside ping-pong mode only the enable clear moves the pointers: one buffer in use

  generate
    for (genvar i = 0; i < NPP; i++) begin : g_ptr
      always_comb begin
        ptr_d[i] = ptr_q[i];
        if (pp_clear || pp_hold) begin
          ptr_d[i] = 1'b0;
        end else if (pkt_run && pp_used && pingpong_toggle[i]) begin
          ptr_d[i] = ~ptr_q[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Output and readback
  // ----------------------------------------
  always_comb begin
    // Readback uses next state so it agrees with the pins
    rd_d = 8'h00;
    rd_d[`USBSC_BIT_PPRST] = pprst_d;
    rd_d[`USBSC_BIT_SE0] = se0_q[1];
    rd_d[`USBSC_BIT_PKT_DISABLE] = pkt_dis_d;
    rd_d[`USBSC_BIT_EN] = en_d;
    rd_d[`USBSC_BIT_RESUME] = resume_d;
    rd_d[`USBSC_BIT_SUSPEND] = susp_d;
    // Disabled module ignores every other control bit
    pull_d = en_d && pullup_cfg_en;
    pkt_d = en_d && !pkt_dis_d && !susp_d;
    keep_d = en_d && pkt_dis_d;
    res_d = en_d && resume_d;
    eclk_d = en_d && !susp_d;
    lp_d = en_d && susp_d;
    // Resume must still reach the lines while suspended
    idle_d = !en_d || (susp_d && !resume_d);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clk_ok_q <= 2'b00;
      se0_q <= 2'b00;
      en_q <= 1'b0;
      pprst_q <= 1'b0;
      pkt_dis_q <= 1'b0;
      resume_q <= 1'b0;
      susp_q <= 1'b0;
      ptr_q <= '0;
      rd_q <= `USBSC_CTL_RESET;
      pull_q <= 1'b0;
      pkt_q <= 1'b0;
      keep_q <= 1'b0;
      res_q <= 1'b0;
      eclk_q <= 1'b0;
      lp_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      clk_ok_q <= clk_ok_d;
      se0_q <= se0_d;
      en_q <= en_d;
      pprst_q <= pprst_d;
      pkt_dis_q <= pkt_dis_d;
      resume_q <= resume_d;
      susp_q <= susp_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      pull_q <= pull_d;
      pkt_q <= pkt_d;
      keep_q <= keep_d;
      res_q <= res_d;
      eclk_q <= eclk_d;
      lp_q <= lp_d;
      idle_q <= idle_d;
    end
  end

  assign ctl.ctl_rdata = rd_q;
  assign module_enable = en_q;
  assign pullup_on = pull_q;
  assign pingpong_pointer_bit = ptr_q;
  assign packet_proc_en = pkt_q;
  assign status_fifo_retain = keep_q;
  assign resume_drive = res_q;
  assign engine_clk_en = eclk_q;
  assign low_power = lp_q;
  assign xcvr_tx_idle = idle_q;

endmodule : usbsc_sie_ctl

// ### verif/usbsc_assertions.sv
// Purpose: Interface checks on the control byte link
// Assumes: One clock; synchronous active-low reset
// Notes: SE0 bit is live, so it is left out of stability checks
module usbsc_assertions #(
  parameter int RESUME_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control byte link
  input wire logic ctl_wr,
  input wire usbsc_pkg::usbsc_byte_t ctl_wdata,
  input wire usbsc_pkg::usbsc_byte_t ctl_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Resume length counter
  // ----------------------------------------
  int res_cnt_q;
  int res_cnt_d;
  always_comb begin
    res_cnt_d = ctl_rdata[2] ? res_cnt_q + 1 : 0;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      res_cnt_q <= 0;
    end else begin
      res_cnt_q <= res_cnt_d;
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_wr;
    ctl_wr;
  endsequence
  sequence s_quiet;
    !ctl_wr;
  endsequence

  property p_unused;
    ctl_rdata[7] == 1'b0 && ctl_rdata[0] == 1'b0;
  endproperty
  a_unused: assert property (p_unused) else $error("unused bits not zero");
  property p_pp_store;
    s_wr |=> ctl_rdata[6] == $past(ctl_wdata[6]);
  endproperty
  a_pp_store: assert property (p_pp_store) else $error("pingpong reset not stored");
  property p_res_store;
    s_wr |=> ctl_rdata[2] == $past(ctl_wdata[2]);
  endproperty
  a_res_store: assert property (p_res_store) else $error("resume not stored");
  property p_sus_store;
    s_wr |=> ctl_rdata[1] == $past(ctl_wdata[1]);
  endproperty
  a_sus_store: assert property (p_sus_store) else $error("suspend not stored");
  property p_pp_hold;
    s_quiet |=> $stable(ctl_rdata[6]);
  endproperty
  a_pp_hold: assert property (p_pp_hold) else $error("pingpong reset changed alone");
  property p_en_rise;
    $rose(ctl_rdata[3]) |-> $past(ctl_wr) && $past(ctl_wdata[3]);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("enable rose without write");
  property p_en_keep;
    s_quiet |=> $stable(ctl_rdata[3]);
  endproperty
  a_en_keep: assert property (p_en_keep) else $error("enable changed alone");
  property p_pkt_en;
    $rose(ctl_rdata[4]) |-> ctl_rdata[3];
  endproperty
  a_pkt_en: assert property (p_pkt_en) else $error("packet disable set while off");
  property p_res_len;
    $fell(ctl_rdata[2]) |-> res_cnt_q >= RESUME_CYC;
  endproperty
  a_res_len: assert property (p_res_len) else $error("resume too short");
endmodule : usbsc_assertions

// ### verif/tb_usb_sie_control.sv
// Purpose: Bench for firmware controller and SIE control joined
// Assumes: Short PLL and resume counts
// Notes: Output vector is enable,pullup,pkt_en,retain,resume,clk_en,low_power,tx_idle
module tb_usb_sie_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int RES = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hrdata;
  logic hreadyout, hresp, pll_on;
  logic bus_idle_interrupt = 1'b0;
  logic bus_activity_interrupt = 1'b0;
  logic clk_src_active = 1'b0;
  logic se0_line = 1'b0;
  logic pullup_cfg_en = 1'b1;
  logic setup_token_rx = 1'b0;
  logic [1:0] pingpong_mode = 2'h1;
  logic [15:0] pingpong_toggle = 16'h0000;
  logic [15:0] pingpong_pointer_bit;
  logic module_enable, pullup_on, packet_proc_en, status_fifo_retain;
  logic resume_drive, engine_clk_en, low_power, xcvr_tx_idle;
  logic [7:0] outs;
  int fail_count = 0;
  int tests_run = 0;
  assign outs = {module_enable, pullup_on, packet_proc_en, status_fifo_retain,
                 resume_drive, engine_clk_en, low_power, xcvr_tx_idle};
  always #5 clk = ~clk;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  usbsc_if u_usbsc_if ();
  usbsc_fw_ctrl #(.PLL_LOCK_CYC(20), .RESUME_CYC(RES)) u_usbsc_fw_ctrl (.clk(clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bus_idle_interrupt(bus_idle_interrupt), .bus_activity_interrupt(bus_activity_interrupt),
    .pll_on(pll_on), .ctl(u_usbsc_if.fw));
  usbsc_sie_ctl #(.NPP(16)) u_usbsc_sie_ctl (.clk(clk), .rst_n(rst_n), .ctl(u_usbsc_if.dev),
    .clk_src_active(clk_src_active), .se0_line(se0_line), .pullup_cfg_en(pullup_cfg_en),
    .pingpong_mode(pingpong_mode), .setup_token_rx(setup_token_rx), .pingpong_toggle(pingpong_toggle),
    .module_enable(module_enable), .pullup_on(pullup_on), .pingpong_pointer_bit(pingpong_pointer_bit),
    .packet_proc_en(packet_proc_en), .status_fifo_retain(status_fifo_retain), .resume_drive(resume_drive),
    .engine_clk_en(engine_clk_en), .low_power(low_power), .xcvr_tx_idle(xcvr_tx_idle));
  usbsc_assertions #(.RESUME_CYC(RES)) u_usbsc_assertions (.clk(clk), .rst_n(rst_n),
    .ctl_wr(u_usbsc_if.ctl_wr), .ctl_wdata(u_usbsc_if.ctl_wdata), .ctl_rdata(u_usbsc_if.ctl_rdata));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
  endtask : ahb
  // Three cycles cover the strobe plus the device register stage
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
    cyc(3);
  endtask : wr
  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0000_0000, r);
    chk(n, r, e);
  endtask : rdc
  task automatic tog(input logic [15:0] v);
    pingpong_toggle <= v;
    @(posedge clk);
    pingpong_toggle <= 16'h0000;
    cyc(3);
  endtask : tog
  task automatic idle_pulse(input logic act);
    bus_idle_interrupt <= !act;
    bus_activity_interrupt <= act;
    @(posedge clk);
    bus_idle_interrupt <= 1'b0;
    bus_activity_interrupt <= 1'b0;
    cyc(8);
  endtask : idle_pulse

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    chk("outs", outs, 32'h0000_0001);
    chk("pll_on", pll_on, 32'h0000_0000);
    chk("hresp", hresp, 32'h0000_0000);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0000);
    rdc("stat", 32'h0000_0004, 32'h0000_0100);
    rdc("unmapped", 32'h0000_0040, 32'h0000_0000);
    $display("test reset done");
  endtask : t_reset
  // No clock source: enable must be refused, other bits inert
  task automatic t_refuse;
    wr(32'h0000_0000, 32'h0000_0008);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0002);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0002);
    chk("outs", outs, 32'h0000_0001);
    wr(32'h0000_0000, 32'h0000_0000);
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_attach;
    clk_src_active <= 1'b1;
    cyc(3);
    wr(32'h0000_0008, 32'h0000_0001);
    cyc(30);
    chk("outs", outs, 32'h0000_00E4);
    chk("pll_on", pll_on, 32'h0000_0001);
    pullup_cfg_en <= 1'b0;
    cyc(2);
    chk("outs", outs, 32'h0000_00A4);
    pullup_cfg_en <= 1'b1;
    chk("pointers", pingpong_pointer_bit, 32'h0000_0000);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0008);
    rdc("stat", 32'h0000_0004, 32'h0000_0908);
    se0_line <= 1'b1;
    cyc(4);
    rdc("se0", 32'h0000_0000, 32'h0000_0028);
    se0_line <= 1'b0;
    cyc(4);
    rdc("se0", 32'h0000_0000, 32'h0000_0008);
    $display("test attach done");
  endtask : t_attach
  task automatic t_pingpong;
    tog(16'h0005);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0005);
    wr(32'h0000_0000, 32'h0000_0048);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0000);
    tog(16'h0003);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0000);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0048);
    wr(32'h0000_0000, 32'h0000_0008);
    tog(16'h0003);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0003);
    // Without ping-pong the reset bit must leave the pointers alone
    pingpong_mode <= 2'h0;
    wr(32'h0000_0000, 32'h0000_0048);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0003);
    wr(32'h0000_0000, 32'h0000_0008);
    pingpong_mode <= 2'h1;
    wr(32'h0000_0000, 32'h0000_0000);
    wr(32'h0000_0000, 32'h0000_0008);
    chk("pointers", pingpong_pointer_bit, 32'h0000_0000);
    $display("test pingpong done");
  endtask : t_pingpong
  task automatic t_setup;
    setup_token_rx <= 1'b1;
    @(posedge clk);
    setup_token_rx <= 1'b0;
    cyc(3);
    chk("outs", outs, 32'h0000_00D4);
    wr(32'h0000_0000, 32'h0000_0018);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0018);
    wr(32'h0000_0000, 32'h0000_0008);
    chk("outs", outs, 32'h0000_00E4);
    wr(32'h0000_0000, 32'h0000_0018);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0008);
    $display("test setup done");
  endtask : t_setup
  task automatic t_suspend;
    wr(32'h0000_0008, 32'h0000_0004);
    idle_pulse(1'b0);
    chk("outs", outs, 32'h0000_00C3);
    rdc("ctrl", 32'h0000_0000, 32'h0000_000A);
    idle_pulse(1'b1);
    chk("outs", outs, 32'h0000_00E4);
    $display("test suspend done");
  endtask : t_suspend
  // Counted on the falling edge to stay clear of the update edge
  task automatic t_wake;
    logic [31:0] r;
    int n;
    n = 0;
    idle_pulse(1'b0);
    ahb(1'b1, 32'h0000_0008, 32'h0000_0006, r);
    repeat (120) begin
      @(negedge clk);
      if (resume_drive === 1'b1) n++;
    end
    @(posedge clk);
    chk("resume_len", (n >= RES) && (n < RES + 10), 32'h0000_0001);
    chk("outs", outs, 32'h0000_00E4);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0008);
    $display("test wake done");
  endtask : t_wake

  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    cyc(5);
    rst_n <= 1'b1;
    t_reset();
    t_refuse();
    t_attach();
    t_pingpong();
    t_setup();
    t_suspend();
    t_wake();
    print_verdict();
  end
  initial begin
    cyc(5000);
    fail_count++;
    print_verdict();
  end
endmodule : tb_usb_sie_control
